// ---- pkg/fpc_pkg.sv ----
package fpc_pkg;

   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned BLK_W     = 2;
   localparam int unsigned OFS_W     = ADDR_W - BLK_W;
   localparam int unsigned DATA_W    = 8;
   localparam int unsigned SUM_W     = 16;
   localparam int unsigned PIN_W     = 8;
   localparam int unsigned FLASH_LEN = 256;

   localparam logic [DATA_W-1:0] ERASED_BYTE    = 8'hff;
   localparam logic [ADDR_W-1:0] ADDR_FIRST     = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_LAST      = 8'hff;
   localparam logic [ADDR_W-1:0] ADDR_STEP      = 8'h01;
   localparam logic [OFS_W-1:0]  OFS_FIRST      = 6'h00;
   localparam logic [OFS_W-1:0]  OFS_LAST       = 6'h3f;
   localparam logic [SUM_W-1:0]  SUM_INIT       = 16'h0000;
   localparam logic [PIN_W-1:0]  PIN_RST_LEVEL  = 8'h00;
   localparam logic [PIN_W-1:0]  PIN_RST_OE_N   = 8'hff;

   typedef enum logic [2:0]
   {
      FPC_OP_CHIP_ERASE  = 3'h0,
      FPC_OP_BLOCK_ERASE = 3'h1,
      FPC_OP_WRITE       = 3'h2,
      FPC_OP_CHECKSUM    = 3'h3,
      FPC_OP_BLANK       = 3'h4,
      FPC_OP_SEC_SET     = 3'h5
   } fpc_op_e;

   typedef enum logic
   {
      FPC_SP_BLOCK_ERASE = 1'b0,
      FPC_SP_BYTE_WRITE  = 1'b1
   } fpc_sp_op_e;

   typedef enum logic
   {
      FPC_RESP_ACK = 1'b0,
      FPC_RESP_NAK = 1'b1
   } fpc_resp_e;

   typedef enum logic [2:0]
   {
      FPC_ST_IDLE  = 3'h0,
      FPC_ST_ERASE = 3'h1,
      FPC_ST_WDATA = 3'h2,
      FPC_ST_WPROG = 3'h3,
      FPC_ST_WVER  = 3'h4,
      FPC_ST_SCAN  = 3'h5
   } fpc_state_e;

   typedef struct packed
   {
      logic chip_erase;
      logic block_erase;
      logic write;
   } fpc_sec_s;

   localparam fpc_sec_s SEC_SHIPPED = 3'h0;

   typedef struct packed
   {
      fpc_op_e             op;
      logic [BLK_W-1:0]    block;
      logic [ADDR_W-1:0]   first;
      logic [ADDR_W-1:0]   last;
      fpc_sec_s            sec;
   } fpc_cmd_s;

   typedef struct packed
   {
      fpc_sp_op_e          op;
      logic [BLK_W-1:0]    block;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
   } fpc_sp_cmd_s;

   typedef struct packed
   {
      logic [PIN_W-1:0]    level;
      logic [PIN_W-1:0]    oe_n;
   } fpc_pins_s;

endpackage : fpc_pkg

// ---- hdl/fpc_flash_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_mem
(
   input  wire logic                        mclk_i,
   input  wire logic                        we_i,
   input  wire logic [fpc_pkg::ADDR_W-1:0]  addr_i,
   input  wire logic [fpc_pkg::DATA_W-1:0]  wdata_i,
   output logic      [fpc_pkg::DATA_W-1:0]  rdata_o
);
   import fpc_pkg::*;

   // Array holds no reset: contents are non-volatile
   logic [DATA_W-1:0] mem [FLASH_LEN];

   always_ff @(posedge mclk_i)
   begin
      if (we_i)
      begin
         mem[addr_i] <= wdata_i;
      end
   end

   assign rdata_o = mem[addr_i];

endmodule : fpc_flash_mem
`default_nettype wire

// ---- hdl/fpc_pin_hold.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpc_pin_hold
(
   input  wire logic               mclk_i,
   input  wire logic               rst_n_i,
   input  wire logic               prog_mode_i,
   input  wire logic               self_mode_i,
   input  wire fpc_pkg::fpc_pins_s app_pins_i,
   output fpc_pkg::fpc_pins_s      pins_o
);
   import fpc_pkg::*;

   fpc_pins_s next_pins;

   always_comb
   begin
      next_pins = app_pins_i;
      if (prog_mode_i)
      begin
         next_pins.level = PIN_RST_LEVEL;
         next_pins.oe_n  = PIN_RST_OE_N;
      end
      else if (self_mode_i)
      begin
         // Halt keeps the pins frozen at their last state
         next_pins = pins_o;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pins_o <= {PIN_RST_LEVEL, PIN_RST_OE_N};
      end
      else
      begin
         pins_o <= next_pins;
      end
   end

endmodule : fpc_pin_hold
`default_nettype wire

// ---- hdl/fpc_cmd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Spare pins held at reset state in programming
// - Self programming pins behave as in halt
// - First programmer command enters programming mode
// - Only programmer commands; device never originates
// - Chip erase clears whole array
// - Block erase clears only the named block
// - Write programs each byte of range, then verifies it
// - Checksum summed over given range
// - Blank check tests whole array erased
// - Every command or data answered ACK/NAK
// - Chip-erase prohibit blocks erases, is permanent
// - Block-erase prohibit; chip erase clears it
// - Write prohibit blocks write and block erase
// - Write allowed under chip-erase or block-erase prohibit
// - New security applies from next mode entry
// - Shipped state has all prohibits clear
// - Flags set only by programmer, any mix
// - Self programming ignores the security flags
module fpc_cmd_top
(
   input  wire logic                        mclk_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        por_n_i,
   input  wire logic                        cmd_valid_i,
   input  wire fpc_pkg::fpc_cmd_s           cmd_i,
   input  wire logic                        data_valid_i,
   input  wire logic [fpc_pkg::DATA_W-1:0]  data_i,
   input  wire logic                        sp_mode_i,
   input  wire logic                        sp_valid_i,
   input  wire fpc_pkg::fpc_sp_cmd_s        sp_cmd_i,
   input  wire fpc_pkg::fpc_pins_s          app_pins_i,
   output logic                             busy_o,
   output logic                             prog_mode_o,
   output logic                             resp_valid_o,
   output fpc_pkg::fpc_resp_e               resp_o,
   output logic      [fpc_pkg::SUM_W-1:0]   sum_o,
   output fpc_pkg::fpc_sec_s                sec_active_o,
   output fpc_pkg::fpc_pins_s               pins_o
);
   import fpc_pkg::*;

   fpc_state_e          state, next_state;
   fpc_op_e             cur_op, next_cur_op;
   logic                from_sp, next_from_sp;
   logic [ADDR_W-1:0]   addr, next_addr;
   logic [ADDR_W-1:0]   last, next_last;
   logic [DATA_W-1:0]   wbyte, next_wbyte;
   logic [SUM_W-1:0]    acc, next_acc;
   logic                blank_ok, next_blank_ok;
   logic                next_busy, next_prog_mode, next_resp_valid;
   fpc_resp_e           next_resp;
   logic [SUM_W-1:0]    next_sum;
   fpc_sec_s            next_sec_active;
   fpc_sec_s            sec_stored, next_sec_stored;
   logic                mem_we;
   logic [DATA_W-1:0]   mem_wdata, mem_rdata;
   logic                cmd_take, sp_take;

   fpc_flash_mem u_mem
   (
      .mclk_i  (mclk_i),
      .we_i    (mem_we),
      .addr_i  (addr),
      .wdata_i (mem_wdata),
      .rdata_o (mem_rdata)
   );

   fpc_pin_hold u_pins
   (
      .mclk_i      (mclk_i),
      .rst_n_i     (rst_n_i),
      .prog_mode_i (prog_mode_o),
      .self_mode_i (sp_mode_i),
      .app_pins_i  (app_pins_i),
      .pins_o      (pins_o)
   );

   // Programmer and self programming never overlap
   assign cmd_take = (state == FPC_ST_IDLE) && cmd_valid_i;
   assign sp_take  = (state == FPC_ST_IDLE) && sp_valid_i && sp_mode_i && !prog_mode_o;

   always_comb
   begin
      next_state      = state;
      next_cur_op     = cur_op;
      next_from_sp    = from_sp;
      next_addr       = addr;
      next_last       = last;
      next_wbyte      = wbyte;
      next_acc        = acc;
      next_blank_ok   = blank_ok;
      next_prog_mode  = prog_mode_o;
      next_resp_valid = 1'b0;
      next_resp       = resp_o;
      next_sum        = sum_o;
      next_sec_active = sec_active_o;
      next_sec_stored = sec_stored;
      mem_we          = 1'b0;
      mem_wdata       = ERASED_BYTE;
      case (state)
         FPC_ST_IDLE:
         begin
            if (cmd_take)
            begin
               next_cur_op  = cmd_i.op;
               next_from_sp = 1'b0;
               if (!prog_mode_o)
               begin
                  next_prog_mode  = 1'b1;
                  next_sec_active = sec_stored;
               end
               // Gating uses flags as latched at this entry
               case (cmd_i.op)
                  FPC_OP_CHIP_ERASE:
                  begin
                     if (prog_mode_o ? sec_active_o.chip_erase : sec_stored.chip_erase)
                     begin
                        next_resp_valid = 1'b1;
                        next_resp       = FPC_RESP_NAK;
                     end
                     else
                     begin
                        next_addr  = ADDR_FIRST;
                        next_last  = ADDR_LAST;
                        next_state = FPC_ST_ERASE;
                     end
                  end
                  FPC_OP_BLOCK_ERASE:
                  begin
                     if (prog_mode_o ? |sec_active_o : |sec_stored)
                     begin
                        next_resp_valid = 1'b1;
                        next_resp       = FPC_RESP_NAK;
                     end
                     else
                     begin
                        next_addr  = {cmd_i.block, OFS_FIRST};
                        next_last  = {cmd_i.block, OFS_LAST};
                        next_state = FPC_ST_ERASE;
                     end
                  end
                  FPC_OP_WRITE:
                  begin
                     // Chip-erase prohibit alone still admits writes
                     if ((prog_mode_o ? sec_active_o.write : sec_stored.write)
                         || (cmd_i.last < cmd_i.first))
                     begin
                        next_resp_valid = 1'b1;
                        next_resp       = FPC_RESP_NAK;
                     end
                     else
                     begin
                        next_resp_valid = 1'b1;
                        next_resp       = FPC_RESP_ACK;
                        next_addr       = cmd_i.first;
                        next_last       = cmd_i.last;
                        next_state      = FPC_ST_WDATA;
                     end
                  end
                  FPC_OP_CHECKSUM,
                  FPC_OP_BLANK:
                  begin
                     if ((cmd_i.op == FPC_OP_CHECKSUM) && (cmd_i.last < cmd_i.first))
                     begin
                        next_resp_valid = 1'b1;
                        next_resp       = FPC_RESP_NAK;
                     end
                     else
                     begin
                        next_addr     = (cmd_i.op == FPC_OP_BLANK) ? ADDR_FIRST : cmd_i.first;
                        next_last     = (cmd_i.op == FPC_OP_BLANK) ? ADDR_LAST : cmd_i.last;
                        next_acc      = SUM_INIT;
                        next_blank_ok = 1'b1;
                        next_state    = FPC_ST_SCAN;
                     end
                  end
                  FPC_OP_SEC_SET:
                  begin
                     // Bits only accumulate, nothing here can clear one
                     next_sec_stored = sec_stored | cmd_i.sec;
                     next_resp_valid = 1'b1;
                     next_resp       = FPC_RESP_ACK;
                  end
                  default:
                  begin
                     next_resp_valid = 1'b1;
                     next_resp       = FPC_RESP_NAK;
                  end
               endcase
            end
            else if (sp_take)
            begin
               // No flag is consulted on this path
               next_from_sp = 1'b1;
               if (sp_cmd_i.op == FPC_SP_BLOCK_ERASE)
               begin
                  next_cur_op = FPC_OP_BLOCK_ERASE;
                  next_addr   = {sp_cmd_i.block, OFS_FIRST};
                  next_last   = {sp_cmd_i.block, OFS_LAST};
                  next_state  = FPC_ST_ERASE;
               end
               else
               begin
                  next_cur_op = FPC_OP_WRITE;
                  next_addr   = sp_cmd_i.addr;
                  next_last   = sp_cmd_i.addr;
                  next_wbyte  = sp_cmd_i.data;
                  next_state  = FPC_ST_WPROG;
               end
            end
         end
         FPC_ST_ERASE:
         begin
            mem_we    = 1'b1;
            mem_wdata = ERASED_BYTE;
            next_addr = addr + ADDR_STEP;
            if (addr == last)
            begin
               next_state      = FPC_ST_IDLE;
               next_resp_valid = 1'b1;
               next_resp       = FPC_RESP_ACK;
               if ((cur_op == FPC_OP_CHIP_ERASE) && !sec_stored.chip_erase)
               begin
                  next_sec_stored.block_erase = 1'b0;
                  next_sec_stored.write       = 1'b0;
                  next_sec_active.block_erase = 1'b0;
                  next_sec_active.write       = 1'b0;
               end
            end
         end
         FPC_ST_WDATA:
         begin
            if (data_valid_i)
            begin
               next_wbyte = data_i;
               next_state = FPC_ST_WPROG;
            end
         end
         FPC_ST_WPROG:
         begin
            // Programming only clears bits, so old data cannot be raised
            mem_we     = 1'b1;
            mem_wdata  = mem_rdata & wbyte;
            next_state = FPC_ST_WVER;
         end
         FPC_ST_WVER:
         begin
            next_resp_valid = 1'b1;
            if (mem_rdata != wbyte)
            begin
               next_resp  = FPC_RESP_NAK;
               next_state = FPC_ST_IDLE;
            end
            else
            begin
               next_resp  = FPC_RESP_ACK;
               next_addr  = addr + ADDR_STEP;
               next_state = ((addr == last) || from_sp) ? FPC_ST_IDLE : FPC_ST_WDATA;
            end
         end
         FPC_ST_SCAN:
         begin
            next_acc      = acc + {{(SUM_W-DATA_W){1'b0}}, mem_rdata};
            next_blank_ok = blank_ok && (mem_rdata == ERASED_BYTE);
            next_addr     = addr + ADDR_STEP;
            if (addr == last)
            begin
               next_state      = FPC_ST_IDLE;
               next_resp_valid = 1'b1;
               if (cur_op == FPC_OP_BLANK)
               begin
                  next_resp = (next_blank_ok) ? FPC_RESP_ACK : FPC_RESP_NAK;
               end
               else
               begin
                  next_resp = FPC_RESP_ACK;
                  next_sum  = next_acc;
               end
            end
         end
         default:
         begin
            next_state = FPC_ST_IDLE;
         end
      endcase
      next_busy = (next_state != FPC_ST_IDLE);
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state        <= FPC_ST_IDLE;
         cur_op       <= FPC_OP_CHIP_ERASE;
         from_sp      <= 1'b0;
         addr         <= ADDR_FIRST;
         last         <= ADDR_FIRST;
         wbyte        <= ERASED_BYTE;
         acc          <= SUM_INIT;
         blank_ok     <= 1'b0;
         busy_o       <= 1'b0;
         prog_mode_o  <= 1'b0;
         resp_valid_o <= 1'b0;
         resp_o       <= FPC_RESP_ACK;
         sum_o        <= SUM_INIT;
         sec_active_o <= SEC_SHIPPED;
      end
      else
      begin
         state        <= next_state;
         cur_op       <= next_cur_op;
         from_sp      <= next_from_sp;
         addr         <= next_addr;
         last         <= next_last;
         wbyte        <= next_wbyte;
         acc          <= next_acc;
         blank_ok     <= next_blank_ok;
         busy_o       <= next_busy;
         prog_mode_o  <= next_prog_mode;
         resp_valid_o <= next_resp_valid;
         resp_o       <= next_resp;
         sum_o        <= next_sum;
         sec_active_o <= next_sec_active;
      end
   end

   // Stored flags survive the programmer reset; only power-on clears all of them
   always_ff @(posedge mclk_i or negedge por_n_i)
   begin
      if (!por_n_i)
      begin
         sec_stored <= SEC_SHIPPED;
      end
      else
      begin
         sec_stored <= next_sec_stored;
      end
   end

   sequence s_blocked_erase;
      cmd_take && prog_mode_o && (cmd_i.op == FPC_OP_BLOCK_ERASE) && (|sec_active_o);
   endsequence

   sequence s_nak_now;
      resp_valid_o && (resp_o == FPC_RESP_NAK) && (state == FPC_ST_IDLE);
   endsequence

   a_blocked_erase_nak: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) s_blocked_erase |=> s_nak_now)
      else $error("blocked block erase not refused");

   a_chip_lock_nak: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      cmd_take && prog_mode_o && (cmd_i.op == FPC_OP_CHIP_ERASE) && sec_active_o.chip_erase
      |=> !busy_o && resp_valid_o && (resp_o == FPC_RESP_NAK))
      else $error("chip erase ran under prohibit");

   a_chip_lock_sticky: assert property (
      @(posedge mclk_i) disable iff (!por_n_i) sec_stored.chip_erase |=> sec_stored.chip_erase)
      else $error("chip-erase prohibit was cleared");

   a_sec_deferred: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      cmd_take && prog_mode_o && (cmd_i.op == FPC_OP_SEC_SET) |=> $stable(sec_active_o))
      else $error("security took effect in same session");

   a_entry_latch: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      cmd_take && !prog_mode_o |=> prog_mode_o && (sec_active_o == $past(sec_stored)))
      else $error("mode entry did not latch flags");

   a_idle_no_write: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i) (state == FPC_ST_IDLE) |-> !mem_we)
      else $error("flash written while idle");

   a_chip_erase_len: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      cmd_take && (cmd_i.op == FPC_OP_CHIP_ERASE) && (next_state == FPC_ST_ERASE)
      |-> ##257 resp_valid_o && (resp_o == FPC_RESP_ACK) && !busy_o)
      else $error("chip erase length wrong");

   a_verify_answer: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      (state == FPC_ST_WPROG) |=> (state == FPC_ST_WVER) ##1 resp_valid_o)
      else $error("write not verified and answered");

   a_sp_ignores_sec: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      sp_take && (sp_cmd_i.op == FPC_SP_BLOCK_ERASE) |=> (state == FPC_ST_ERASE) ##64 resp_valid_o)
      else $error("self erase gated by flags");

   a_no_unasked_resp: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      resp_valid_o |-> $past(busy_o) || $past(cmd_take))
      else $error("response without a command");

   a_pins_reset_state: assert property (
      @(posedge mclk_i) disable iff (!rst_n_i)
      prog_mode_o |=> (pins_o.oe_n == PIN_RST_OE_N) && (pins_o.level == PIN_RST_LEVEL))
      else $error("spare pins not in reset state");

endmodule : fpc_cmd_top
`default_nettype wire

// ---- verification/fpc_prog_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpc_prog_model
(
   input  wire logic                          mclk_i,
   output var  logic                          rst_n_o,
   output var  logic                          cmd_valid_o,
   output var  fpc_pkg::fpc_cmd_s             cmd_o,
   output var  logic                          data_valid_o,
   output var  logic [fpc_pkg::DATA_W-1:0]    data_o
);
   import fpc_pkg::*;

   initial
   begin
      rst_n_o = 1'b0;
      cmd_valid_o = 1'b0;
      cmd_o = '0;
      data_valid_o = 1'b0;
      data_o = '0;
   end

   // Lines flip once released so stale values never look valid
   task automatic issue(input fpc_cmd_s c);
      @(negedge mclk_i);
      cmd_valid_o = 1'b1;
      cmd_o = c;
      @(negedge mclk_i);
      cmd_valid_o = 1'b0;
      cmd_o = ~c;
   endtask : issue

   task automatic beat(input logic [DATA_W-1:0] d);
      @(negedge mclk_i);
      data_valid_o = 1'b1;
      data_o = d;
      @(negedge mclk_i);
      data_valid_o = 1'b0;
      data_o = ~d;
   endtask : beat

   task automatic reset_dev();
      @(negedge mclk_i);
      rst_n_o = 1'b0;
      repeat (3) @(negedge mclk_i);
      rst_n_o = 1'b1;
   endtask : reset_dev
endmodule : fpc_prog_model
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fpc_pkg::*;
   logic mclk_i;
   logic rst_n_i;
   logic por_n_i;
   logic cmd_valid_i;
   fpc_cmd_s cmd_i;
   logic data_valid_i;
   logic [DATA_W-1:0] data_i;
   logic sp_mode_i;
   logic sp_valid_i;
   fpc_sp_cmd_s sp_cmd_i;
   fpc_pins_s app_pins_i;
   logic busy_o;
   logic prog_mode_o;
   logic resp_valid_o;
   fpc_resp_e resp_o;
   logic [SUM_W-1:0] sum_o;
   fpc_sec_s sec_active_o;
   fpc_pins_s pins_o;
   int mem [256];
   int st = 0;
   int ac = 0;
   int fail_count = 0;
   int n_checks = 0;
   logic [31:0] seed = 32'd83287;
   fpc_pins_s p;

   fpc_cmd_top u_fpc_cmd_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .data_valid_i(data_valid_i),
      .data_i(data_i), .sp_mode_i(sp_mode_i), .sp_valid_i(sp_valid_i),
      .sp_cmd_i(sp_cmd_i), .app_pins_i(app_pins_i), .busy_o(busy_o),
      .prog_mode_o(prog_mode_o), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
      .sum_o(sum_o), .sec_active_o(sec_active_o), .pins_o(pins_o));
   fpc_prog_model u_fpc_prog_model (.mclk_i(mclk_i), .rst_n_o(rst_n_i),
      .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .data_valid_o(data_valid_i),
      .data_o(data_i));

   initial
   begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Pins churn every cycle so hold logic is really exercised
   initial app_pins_i = '0;
   always @(negedge mclk_i) app_pins_i <= 16'(rnd());

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wait_resp();
      int n;
      n = 0;
      // A one-cycle answer already stands when the strobe drops
      while (resp_valid_o !== 1'b1 && n < 400)
      begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      if (n == 400) fail_count++;
   endtask : wait_resp

   task automatic prog(input fpc_op_e op, input int b, input int f, input int l, input int s);
      logic ok;
      int sum;
      int d;
      ok = 1'b1;
      sum = 0;
      case (op)
         FPC_OP_CHIP_ERASE: ok = (ac & 4) == 0;
         FPC_OP_BLOCK_ERASE: ok = ac == 0;
         FPC_OP_WRITE: ok = (ac & 1) == 0 && l >= f;
         FPC_OP_CHECKSUM: ok = l >= f;
         FPC_OP_SEC_SET: st |= s;
         FPC_OP_BLANK: for (int a = 0; a < 256; a++) ok &= mem[a] == 'hff;
         default: ok = 1'b0;
      endcase
      for (int a = f; a <= l; a++) sum += mem[a];
      if (ok && op == FPC_OP_CHIP_ERASE)
      begin
         foreach (mem[a]) mem[a] = 'hff;
         if ((st & 4) == 0)
         begin
            st &= 4;
            ac &= 4;
         end
      end
      if (ok && op == FPC_OP_BLOCK_ERASE)
         for (int a = 0; a < 64; a++) mem[b * 64 + a] = 'hff;
      u_fpc_prog_model.issue(fpc_cmd_s'{op, b[1:0], f[7:0], l[7:0], fpc_sec_s'(s[2:0])});
      wait_resp();
      chk(resp_o, ok ? FPC_RESP_ACK : FPC_RESP_NAK);
      chk(busy_o, ok && op == FPC_OP_WRITE);
      if (ok && op == FPC_OP_CHECKSUM) chk(sum_o, sum[15:0]);
      if (ok && op == FPC_OP_WRITE)
         for (int a = f; a <= l && ok; a++)
         begin
            d = rnd() & 'hff;
            ok = (mem[a] & d) == d;
            mem[a] &= d;
            u_fpc_prog_model.beat(d[7:0]);
            wait_resp();
            chk(resp_o, ok ? FPC_RESP_ACK : FPC_RESP_NAK);
            chk(busy_o, ok && a < l);
         end
   endtask : prog

   task automatic sp(input fpc_sp_op_e op, input int a, input int d);
      logic ok;
      ok = op == FPC_SP_BLOCK_ERASE || (mem[a] & d) == d;
      if (op == FPC_SP_BLOCK_ERASE)
         for (int i = 0; i < 64; i++) mem[(a & 'hc0) + i] = 'hff;
      else
         mem[a] &= d;
      @(negedge mclk_i);
      sp_valid_i = 1'b1;
      sp_cmd_i = '{op, a[7:6], a[7:0], d[7:0]};
      @(negedge mclk_i);
      sp_valid_i = 1'b0;
      sp_cmd_i = ~sp_cmd_i;
      wait_resp();
      chk(resp_o, ok ? FPC_RESP_ACK : FPC_RESP_NAK);
   endtask : sp

   task automatic sess();
      u_fpc_prog_model.reset_dev();
      ac = st;
   endtask : sess

   task automatic summarize();
      if (fail_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   initial
   begin
      #(40 * 20000);
      fail_count++;
      summarize();
   end

   initial
   begin
      por_n_i = 1'b0;
      sp_mode_i = 1'b0;
      sp_valid_i = 1'b0;
      sp_cmd_i = '0;
      u_fpc_prog_model.reset_dev();
      por_n_i = 1'b1;
      chk(sec_active_o, 0);
      chk(prog_mode_o, 0);
      prog(FPC_OP_CHIP_ERASE, 0, 0, 0, 0);
      chk(prog_mode_o, 1);
      chk(pins_o, {PIN_RST_LEVEL, PIN_RST_OE_N});
      prog(FPC_OP_BLANK, 0, 0, 0, 0);
      prog(FPC_OP_WRITE, 0, 'h3c, 'h43, 0);
      prog(FPC_OP_BLANK, 0, 0, 0, 0);
      prog(FPC_OP_BLOCK_ERASE, 1, 0, 0, 0);
      prog(FPC_OP_CHECKSUM, 0, 'h3c, 'h43, 0);
      prog(fpc_op_e'(3'h6), 0, 0, 0, 0);
      prog(FPC_OP_CHECKSUM, 0, 5, 4, 0);
      prog(FPC_OP_SEC_SET, 0, 0, 0, 1);
      prog(FPC_OP_WRITE, 0, 'h80, 'h81, 0);
      sess();
      prog(FPC_OP_WRITE, 0, 'h90, 'h90, 0);
      chk(sec_active_o, ac);
      prog(FPC_OP_BLOCK_ERASE, 2, 0, 0, 0);
      prog(FPC_OP_CHECKSUM, 0, 'h80, 'h81, 0);
      prog(FPC_OP_CHIP_ERASE, 0, 0, 0, 0);
      prog(FPC_OP_WRITE, 0, 'h10, 'h11, 0);
      prog(FPC_OP_SEC_SET, 0, 0, 0, 6);
      sess();
      prog(FPC_OP_CHIP_ERASE, 0, 0, 0, 0);
      chk(sec_active_o, ac);
      prog(FPC_OP_BLOCK_ERASE, 0, 0, 0, 0);
      prog(FPC_OP_WRITE, 0, 'h10, 'h11, 0);
      prog(FPC_OP_WRITE, 0, 'h20, 'h21, 0);
      sess();
      @(negedge mclk_i);
      sp_mode_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      p = pins_o;
      sp(FPC_SP_BLOCK_ERASE, 0, 0);
      sp(FPC_SP_BYTE_WRITE, 5, rnd() & 'hff);
      chk(pins_o, p);
      @(negedge mclk_i);
      sp_mode_i = 1'b0;
      prog(FPC_OP_CHECKSUM, 0, 'h00, 'h3f, 0);
      prog(FPC_OP_CHIP_ERASE, 0, 0, 0, 0);
      summarize();
   end
endmodule : tb
`default_nettype wire
